// file: logic/burst_offset.sv
// burst counter: low address bits for a given beat of a four-word burst
`timescale 1ns/100ps
module burst_offset (
	// burst position
	input  wire logic [sram_pkg::BEAT_W-1:0] start,
	input  wire logic [sram_pkg::BEAT_W-1:0] beat,
	// order: high selects interleaved
	input  wire logic                        interleave,
	// resulting low address bits
	output logic      [sram_pkg::BEAT_W-1:0] offset
);

	// both orders wrap inside the four-word group
	always_comb begin
		if (interleave) begin
			offset = start ^ beat;
		end else begin
			offset = start + beat;
		end
	end

endmodule : burst_offset

// file: logic/pipelined_burst_sram.sv
// pipelined synchronous sram with burst counter and two-cycle data phase
`timescale 1ns/100ps

module pipelined_burst_sram (
	// clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	// synchronous control
	input  wire logic                        clock_enable_n,
	input  wire logic                        advance_or_load,
	input  wire logic                        read_not_write,
	input  wire logic                        chip_select_a_n,
	input  wire logic                        chip_select_hi,
	input  wire logic                        chip_select_b_n,
	input  wire logic [sram_pkg::BYTES-1:0]  byte_write_n,
	input  wire logic [sram_pkg::ADDR_W-1:0] address,
	// static burst order
	input  wire logic                        burst_order_select,
	// asynchronous controls
	input  wire logic                        output_enable_n,
	input  wire logic                        sleep_request,
	// data pins, enable low while driving
	input  wire logic [sram_pkg::DATA_W-1:0] dq_in,
	output logic      [sram_pkg::DATA_W-1:0] dq_out,
	output logic                             dq_oe_n
);

	// ************************************************************
	// decode helpers
	// ************************************************************
	function automatic logic chip_selected(
		input logic a_n,
		input logic hi,
		input logic b_n
	);
		chip_selected = !a_n && hi && !b_n;
	endfunction : chip_selected

	function automatic sram_pkg::cycle_e cycle_kind(
		input logic adv,
		input logic sel,
		input logic burst_on
	);
		if (!adv && sel) begin
			cycle_kind = sram_pkg::CYC_LOAD;
		end else if (!adv) begin
			cycle_kind = sram_pkg::CYC_DESELECT;
		end else if (burst_on) begin
			cycle_kind = sram_pkg::CYC_ADVANCE;
		end else begin
			cycle_kind = sram_pkg::CYC_NOOP;
		end
	endfunction : cycle_kind

	// ************************************************************
	// state
	// ************************************************************
	sram_pkg::state_s            st_q;
	sram_pkg::state_s            st_d;
	sram_pkg::cycle_e            kind;
	logic                        accept;
	logic [sram_pkg::BEAT_W-1:0] beat_nx;
	logic [sram_pkg::BEAT_W-1:0] burst_lo;
	logic [sram_pkg::DATA_W-1:0] rd_word;
	logic                        mem_we;
	logic                        mem_re;

	// sleep acts like a held clock enable: nothing moves but the
	// synchronisers and the output enable
	assign accept  = !clock_enable_n && !st_q.sleep_sync && !rst;
	assign kind    = cycle_kind(advance_or_load,
		chip_selected(chip_select_a_n, chip_select_hi, chip_select_b_n),
		st_q.burst_on);
	assign beat_nx = st_q.beat + sram_pkg::BEAT_STEP;

	burst_offset u_burst (
		.start      (st_q.base[sram_pkg::BEAT_W-1:0]),
		.beat       (beat_nx),
		.interleave (burst_order_select),
		.offset     (burst_lo)
	);

	// ************************************************************
	// array: read issued one edge after acceptance, write at second
	// ************************************************************
	assign mem_re = accept && st_q.s1.valid && st_q.s1.rd;
	assign mem_we = accept && st_q.s2.valid && !st_q.s2.rd;

	sram_array u_array (
		.core_clk (core_clk),
		.rst      (rst),
		.we       (mem_we),
		.be       (st_q.s2.bwe),
		.waddr    (st_q.s2.addr),
		.wdata    (dq_in),
		.re       (mem_re),
		.raddr    (st_q.s1.addr),
		.rdata    (rd_word)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_d = st_q;
		st_d.oe_n_meta  = output_enable_n;
		st_d.oe_n_sync  = st_q.oe_n_meta;
		st_d.sleep_meta = sleep_request;
		st_d.sleep_sync = st_q.sleep_meta;
		if (accept) begin
			st_d.s2    = st_q.s1;
			st_d.drive = st_q.s2.valid && st_q.s2.rd;
			if (st_q.s2.valid && st_q.s2.rd) begin
				st_d.dq_out = rd_word;
			end
			case (kind)
				sram_pkg::CYC_LOAD: begin
					st_d.burst_on = 1'h1;
					st_d.dir_rd   = read_not_write;
					st_d.base     = address;
					st_d.beat     = sram_pkg::BEAT_FIRST;
					st_d.s1.valid = 1'h1;
					st_d.s1.rd    = read_not_write;
					st_d.s1.addr  = address;
					st_d.s1.bwe   = read_not_write ? '0 : ~byte_write_n;
				end
				sram_pkg::CYC_ADVANCE: begin
					st_d.beat     = beat_nx;
					st_d.s1.valid = 1'h1;
					st_d.s1.rd    = st_q.dir_rd;
					st_d.s1.addr  = {st_q.base[sram_pkg::ADDR_W-1:
						sram_pkg::BEAT_W], burst_lo};
					st_d.s1.bwe   = st_q.dir_rd ? '0 : ~byte_write_n;
				end
				sram_pkg::CYC_DESELECT: begin
					st_d.burst_on = 1'h0;
					st_d.s1       = sram_pkg::OP_IDLE;
				end
				default: begin
					st_d.s1 = sram_pkg::OP_IDLE;
				end
			endcase
		end
		// output enable is honoured even while frozen or asleep
		st_d.dq_oe_n = !(st_d.drive && !st_q.oe_n_sync);
		if (rst) begin
			st_d = sram_pkg::STATE_RESET;
		end
	end

	always_ff @(posedge core_clk) begin
		st_q <= st_d;
	end

	assign dq_out  = st_q.dq_out;
	assign dq_oe_n = st_q.dq_oe_n;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_read_latency: assert property (
		accept && kind == sram_pkg::CYC_LOAD && read_not_write
		##1 accept ##1 accept |=> st_q.drive)
		else $error("read data not driven two edges after load");

	chk_write_float: assert property (
		accept && (kind == sram_pkg::CYC_DESELECT ||
		(kind == sram_pkg::CYC_LOAD && !read_not_write))
		##1 accept ##1 accept |=> st_q.dq_oe_n)
		else $error("bus not floated after deselect or write");

	chk_suspend_hold: assert property (
		!accept |=> $stable(st_q.s1) && $stable(st_q.s2)
		&& $stable(st_q.dq_out) && $stable(st_q.beat))
		else $error("state moved while suspended");

	chk_deselect_idle: assert property (
		accept && kind == sram_pkg::CYC_DESELECT
		|=> !st_q.s1.valid && !st_q.burst_on)
		else $error("deselect started an operation");

	chk_pipe_drain: assert property (
		accept && kind == sram_pkg::CYC_DESELECT && st_q.s1.valid
		|=> st_q.s2.valid)
		else $error("pending transfer dropped on deselect");

	chk_load_capture: assert property (
		accept && kind == sram_pkg::CYC_LOAD
		|=> st_q.s1.valid && st_q.s1.addr == $past(address)
		&& st_q.s1.rd == $past(read_not_write))
		else $error("load did not capture address and direction");

	chk_advance_dir: assert property (
		accept && kind == sram_pkg::CYC_ADVANCE
		|=> st_q.s1.rd == $past(st_q.dir_rd)
		&& st_q.s1.addr[sram_pkg::ADDR_W-1:sram_pkg::BEAT_W]
		== $past(st_q.base[sram_pkg::ADDR_W-1:sram_pkg::BEAT_W]))
		else $error("advance changed direction or upper address");

	chk_read_bytes: assert property (
		accept && kind == sram_pkg::CYC_LOAD && read_not_write
		|=> st_q.s1.bwe == '0)
		else $error("byte enables kept on a read");

	chk_oe_float: assert property (
		st_q.oe_n_sync |=> st_q.dq_oe_n)
		else $error("pins driven with output enable high");

	chk_sleep_hold: assert property (
		st_q.sleep_sync |=> $stable(st_q.s2) && !$past(mem_we))
		else $error("activity while asleep");

	// select decode checked against the pins, not the helper function
	chk_select_miss: assert property (
		accept && !advance_or_load && (chip_select_a_n ||
		!chip_select_hi || chip_select_b_n)
		|-> kind == sram_pkg::CYC_DESELECT)
		else $error("partial select did not deselect");

	chk_select_hit: assert property (
		accept && !advance_or_load && !chip_select_a_n &&
		chip_select_hi && !chip_select_b_n
		|-> kind == sram_pkg::CYC_LOAD)
		else $error("full select did not load");

	chk_load_dir: assert property (
		accept && kind == sram_pkg::CYC_LOAD
		|=> st_q.dir_rd == $past(read_not_write) && st_q.burst_on
		&& st_q.beat == sram_pkg::BEAT_FIRST)
		else $error("load did not open a burst in its direction");

	chk_beat_step: assert property (
		accept && kind == sram_pkg::CYC_ADVANCE
		|=> st_q.beat == $past(st_q.beat) + sram_pkg::BEAT_STEP
		&& $stable(st_q.base))
		else $error("advance did not step the counter alone");

	// linear step judged from the previous beat, not from the base
	chk_linear_order: assert property (
		accept && kind == sram_pkg::CYC_ADVANCE && !burst_order_select
		|=> st_q.s1.addr[sram_pkg::BEAT_W-1:0] ==
		$past(st_q.s1.addr[sram_pkg::BEAT_W-1:0])
		+ sram_pkg::BEAT_STEP)
		else $error("linear burst did not count up by one");

	chk_interleave_order: assert property (
		accept && kind == sram_pkg::CYC_ADVANCE && burst_order_select
		|=> st_q.s1.addr[sram_pkg::BEAT_W-1:0] ==
		(st_q.base[sram_pkg::BEAT_W-1:0] ^ st_q.beat))
		else $error("interleaved burst offset wrong");

	chk_write_bytes: assert property (
		accept && !read_not_write && kind == sram_pkg::CYC_LOAD
		|=> st_q.s1.bwe == ~$past(byte_write_n))
		else $error("load write lost its byte enables");

	chk_burst_bytes: assert property (
		accept && kind == sram_pkg::CYC_ADVANCE && !st_q.dir_rd
		|=> st_q.s1.bwe == ~$past(byte_write_n))
		else $error("burst write lost its byte enables");

	chk_write_commit: assert property (
		accept && kind == sram_pkg::CYC_LOAD && !read_not_write
		##1 accept ##1 accept
		|-> mem_we && st_q.s2.addr == $past(address, 2))
		else $error("write not committed two edges after load");

	chk_read_data: assert property (
		accept && st_q.s2.valid && st_q.s2.rd
		|=> st_q.drive && st_q.dq_out == $past(rd_word))
		else $error("registered read word not presented");

	chk_freeze_drive: assert property (
		!accept && st_q.drive && !st_q.oe_n_sync
		|=> !st_q.dq_oe_n)
		else $error("frozen read dropped its drive");

	cov_load_read: cover property (
		accept && kind == sram_pkg::CYC_LOAD && read_not_write
		##1 accept && kind == sram_pkg::CYC_ADVANCE);
	cov_write_then_read: cover property (
		accept && kind == sram_pkg::CYC_LOAD && !read_not_write
		##1 accept && kind == sram_pkg::CYC_LOAD && read_not_write);
	cov_suspend_mid: cover property (
		st_q.s1.valid && clock_enable_n);
	cov_deselect: cover property (
		accept && kind == sram_pkg::CYC_DESELECT && st_q.burst_on);
	cov_interleave: cover property (
		accept && kind == sram_pkg::CYC_ADVANCE && burst_order_select);

endmodule : pipelined_burst_sram

// file: logic/sram_array.sv
// storage array with byte write enables and a registered read port
`timescale 1ns/100ps
module sram_array (
	// clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         rst,
	// write port
	input  wire logic                         we,
	input  wire logic [sram_pkg::BYTES-1:0]   be,
	input  wire logic [sram_pkg::ADDR_W-1:0]  waddr,
	input  wire logic [sram_pkg::DATA_W-1:0]  wdata,
	// read port
	input  wire logic                         re,
	input  wire logic [sram_pkg::ADDR_W-1:0]  raddr,
	output logic      [sram_pkg::DATA_W-1:0]  rdata
);

	localparam int DEPTH = 1 << sram_pkg::ADDR_W;

	logic [sram_pkg::DATA_W-1:0] mem [DEPTH];
	logic [sram_pkg::DATA_W-1:0] fwd;
	logic [sram_pkg::DATA_W-1:0] rdata_q;

	// a write landing on the word being read is forwarded, so a read
	// issued right behind a write sees the new bytes
	always_comb begin
		fwd = mem[raddr];
		for (int i = 0; i < sram_pkg::BYTES; i++) begin
			if (we && be[i] && (waddr == raddr)) begin
				fwd[i*sram_pkg::BYTE_W +: sram_pkg::BYTE_W] =
					wdata[i*sram_pkg::BYTE_W +: sram_pkg::BYTE_W];
			end
		end
	end

	// array has no reset: contents survive reset and sleep
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < sram_pkg::BYTES; i++) begin
			if (we && be[i]) begin
				mem[waddr][i*sram_pkg::BYTE_W +: sram_pkg::BYTE_W] <=
					wdata[i*sram_pkg::BYTE_W +: sram_pkg::BYTE_W];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (re) begin
			rdata_q <= fwd;
		end
	end

	assign rdata = rdata_q;

endmodule : sram_array

// file: shared/sram_pkg.sv
// shared constants, command types and state layout of the pipelined sram
package sram_pkg;

	// ************************************************************
	// geometry
	// ************************************************************
	localparam int ADDR_W = 18;
	localparam int DATA_W = 36;
	localparam int BYTE_W = 9;
	localparam int BYTES  = 4;
	localparam int BEAT_W = 2;

	localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
	localparam logic [BEAT_W-1:0] BEAT_STEP  = 2'h1;

	// ************************************************************
	// cycle kinds and pipeline carriers
	// ************************************************************
	typedef enum logic [1:0] {
		CYC_NOOP     = 2'b00,
		CYC_LOAD     = 2'b01,
		CYC_ADVANCE  = 2'b10,
		CYC_DESELECT = 2'b11
	} cycle_e;

	typedef struct packed {
		logic              valid;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [BYTES-1:0]  bwe;
	} op_s;

	typedef struct packed {
		logic              oe_n_meta;
		logic              oe_n_sync;
		logic              sleep_meta;
		logic              sleep_sync;
		logic              burst_on;
		logic              dir_rd;
		logic [ADDR_W-1:0] base;
		logic [BEAT_W-1:0] beat;
		op_s               s1;
		op_s               s2;
		logic              drive;
		logic [DATA_W-1:0] dq_out;
		logic              dq_oe_n;
	} state_s;

	localparam op_s OP_IDLE = '0;

	localparam state_s STATE_RESET = '{
		oe_n_meta:  1'h1,
		oe_n_sync:  1'h1,
		sleep_meta: 1'h0,
		sleep_sync: 1'h0,
		burst_on:   1'h0,
		dir_rd:     1'h1,
		base:       '0,
		beat:       BEAT_FIRST,
		s1:         OP_IDLE,
		s2:         OP_IDLE,
		drive:      1'h0,
		dq_out:     '0,
		dq_oe_n:    1'h1
	};

endpackage : sram_pkg

// file: tb/pipelined_burst_sync_sram_tb_top.sv
// self-checking bench of the pipelined burst sram
`timescale 1ns/100ps
module pipelined_burst_sync_sram_tb_top;
	// ********
	// wiring
	// ********
	localparam logic [17:0] A = 18'h00135;
	localparam logic [17:0] B = 18'h02a40;
	localparam logic [35:0] D = 36'h9a5c3e17b;
	logic core_clk, rst, burst_order_select, output_enable_n;
	logic sleep_request, dq_oe_n, clock_enable_n, advance_or_load;
	logic read_not_write, chip_select_a_n, chip_select_hi;
	logic chip_select_b_n;
	logic [3:0]  byte_write_n;
	logic [17:0] address;
	logic [35:0] dq_in, dq_out, mem_a;
	logic [35:0] mem [4];
	int n_errors = 0;
	int tests_run = 0;
	sram_ctrl_model m (.core_clk, .clock_enable_n, .advance_or_load,
		.read_not_write, .chip_select_a_n, .chip_select_hi,
		.chip_select_b_n, .byte_write_n, .address, .dq_in);
	pipelined_burst_sram uut (.core_clk, .rst, .clock_enable_n,
		.advance_or_load, .read_not_write, .chip_select_a_n,
		.chip_select_hi, .chip_select_b_n, .byte_write_n, .address,
		.burst_order_select, .output_enable_n, .sleep_request,
		.dq_in, .dq_out, .dq_oe_n);
	initial begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end
	task chk_d(input logic [35:0] g, e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk_d
	task chk_f(input logic g, e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: flag %h expected %h", $time, g, e);
		end
	endtask : chk_f
	task test_done;
		if (n_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	function logic [1:0] off(input logic [1:0] s, k, input logic il);
		return il ? s ^ k : s + k;
	endfunction : off
	// deselect carries write-like controls; must not start anything
	task fill(input sram_pkg::cycle_e k, input int ds);
		m.cmd(k, 1'h0, A, 4'h0, 1'h0, '0, ds);
	endtask : fill
	task rd_chk(input logic [17:0] a, input logic [35:0] e, input int ds,
		input sram_pkg::cycle_e k, input logic oe);
		m.cmd(sram_pkg::CYC_LOAD, 1'h1, a, 4'h0, 1'h0, '0, 0);
		fill(sram_pkg::CYC_DESELECT, ds);
		fill(k, 0);
		fill(k, 0);
		chk_f(dq_oe_n, oe);
		if (!oe)
			chk_d(dq_out, e);
		fill(k, 0);
		chk_f(dq_oe_n, 1'h1);
		fill(k, 0);
		chk_f(dq_oe_n, 1'h1);
	endtask : rd_chk
	// ********
	// scenarios
	// ********
	task t_bytes;
		mem_a = D;
		m.cmd(sram_pkg::CYC_LOAD, 1'h0, A, 4'h0, 1'h1, D, 0);
		rd_chk(A, D, 0, sram_pkg::CYC_DESELECT, 1'h0);
		for (int b = 0; b < 4; b++) begin
			m.cmd(sram_pkg::CYC_LOAD, 1'h0, A, ~(4'h1 << b), 1'h1, ~D, 0);
			mem_a[9*b+:9] = ~D[9*b+:9];
			rd_chk(A, mem_a, b % 3, b[0] ? sram_pkg::CYC_NOOP :
				sram_pkg::CYC_DESELECT, 1'h0);
		end
	endtask : t_bytes
	task t_burst;
		for (int o = 0; o < 2; o++) begin
			burst_order_select = o[0];
			for (int k = 0; k < 4; k++) begin
				mem[off(2'h1, k[1:0], o[0])] = D + 36'(k + 4 * o);
				m.cmd(k ? sram_pkg::CYC_ADVANCE : sram_pkg::CYC_LOAD,
					k > 0, k ? ~B : B + 18'h1, 4'h0, 1'h1,
					D + 36'(k + 4 * o), 0);
			end
			for (int k = 0; k < 4; k++)
				m.cmd(k ? sram_pkg::CYC_ADVANCE : sram_pkg::CYC_LOAD,
					k == 0, k ? ~B : B + 18'h2, 4'h0, 1'h0, '0, 0);
			for (int k = 0; k < 4; k++) begin
				if (k > 0)
					fill(sram_pkg::CYC_DESELECT, 0);
				chk_d(dq_out, mem[off(2'h2, k[1:0], o[0])]);
			end
			fill(sram_pkg::CYC_DESELECT, 0);
			chk_f(dq_oe_n, 1'h1);
		end
	endtask : t_burst
	task t_suspend;
		// suspend right behind the load: frozen edges must not count
		m.cmd(sram_pkg::CYC_LOAD, 1'h1, A, 4'h0, 1'h0, '0, 0);
		m.idle(2);
		fill(sram_pkg::CYC_DESELECT, 0);
		chk_f(dq_oe_n, 1'h1);
		fill(sram_pkg::CYC_DESELECT, 0);
		chk_f(dq_oe_n, 1'h1);
		m.idle(3);
		chk_d(dq_out, mem_a);
		chk_f(dq_oe_n, 1'h0);
		fill(sram_pkg::CYC_DESELECT, 0);
		chk_f(dq_oe_n, 1'h0);
		fill(sram_pkg::CYC_DESELECT, 0);
		chk_f(dq_oe_n, 1'h1);
	endtask : t_suspend
	task t_async;
		output_enable_n = 1'h1;
		repeat (3) fill(sram_pkg::CYC_DESELECT, 0);
		rd_chk(A, mem_a, 0, sram_pkg::CYC_DESELECT, 1'h1);
		output_enable_n = 1'h0;
		sleep_request = 1'h1;
		repeat (3) fill(sram_pkg::CYC_DESELECT, 0);
		m.cmd(sram_pkg::CYC_LOAD, 1'h0, A, 4'h0, 1'h1, ~mem_a, 0);
		repeat (3) fill(sram_pkg::CYC_DESELECT, 0);
		sleep_request = 1'h0;
		repeat (3) fill(sram_pkg::CYC_DESELECT, 0);
		rd_chk(A, mem_a, 1, sram_pkg::CYC_DESELECT, 1'h0);
	endtask : t_async
	initial begin
		rst = 1'h1;
		{burst_order_select, output_enable_n, sleep_request} = 3'h0;
		repeat (5) @(posedge core_clk);
		#1;
		rst = 1'h0;
		t_bytes();
		t_burst();
		t_suspend();
		t_async();
		test_done();
	end
	// whole run needs about 100 cycles
	initial begin
		repeat (2000) @(posedge core_clk);
		n_errors++;
		test_done();
	end
endmodule : pipelined_burst_sync_sram_tb_top

// file: tb/sram_ctrl_model.sv
// memory controller model: commands and delayed write data
`timescale 1ns/100ps
module sram_ctrl_model (
	// clock
	input  wire logic                        core_clk,
	// command pins
	output logic                             clock_enable_n,
	output logic                             advance_or_load,
	output logic                             read_not_write,
	output logic                             chip_select_a_n,
	output logic                             chip_select_hi,
	output logic                             chip_select_b_n,
	output logic [sram_pkg::BYTES-1:0]       byte_write_n,
	output logic [sram_pkg::ADDR_W-1:0]      address,
	// write data
	output logic [sram_pkg::DATA_W-1:0]      dq_in
);
	// ********
	// write data pipe
	// ********
	logic [sram_pkg::DATA_W-1:0] d0, p1, p2, last;
	logic                        v0, v1, v2;
	initial begin
		{clock_enable_n, advance_or_load, read_not_write} = 3'h7;
		{chip_select_a_n, chip_select_hi, chip_select_b_n} = 3'h5;
		byte_write_n = 4'hf;
		address = '0;
		{v0, v1, v2} = 3'h0;
		{d0, p1, p2, last} = '0;
	end
	// released pins show the inverse, never a held word
	assign dq_in = v2 ? p2 : ~last;
	// suspended edges do not move the data phase
	always @(posedge core_clk) begin
		if (!clock_enable_n) begin
			p1 <= d0;
			v1 <= v0;
			p2 <= p1;
			v2 <= v1;
		end
		if (v2)
			last <= p2;
	end
	task cmd(input sram_pkg::cycle_e k, input logic rd,
		input logic [sram_pkg::ADDR_W-1:0] a, input logic [3:0] bw,
		input logic wd, input logic [sram_pkg::DATA_W-1:0] d,
		input int ds);
		@(posedge core_clk);
		#1;
		clock_enable_n = 1'h0;
		advance_or_load = (k == sram_pkg::CYC_ADVANCE ||
			k == sram_pkg::CYC_NOOP);
		read_not_write = rd;
		chip_select_a_n = (k == sram_pkg::CYC_DESELECT && ds == 0);
		chip_select_hi = !(k == sram_pkg::CYC_DESELECT && ds == 1);
		chip_select_b_n = (k == sram_pkg::CYC_DESELECT && ds == 2);
		byte_write_n = bw;
		address = a;
		v0 = wd;
		d0 = d;
	endtask : cmd
	task idle(input int n);
		repeat (n) begin
			@(posedge core_clk);
			#1;
			clock_enable_n = 1'h1;
		end
	endtask : idle
endmodule : sram_ctrl_model
